// file: inc/adcsq_pkg.sv
// Package with register map, field layout, timing and state types of the ADC sequencer
package adcsq_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] OFF_CTRL   = 12'h000; // converter_control_register
   localparam logic [11:0] OFF_RESULT = 12'h004; // conversion_result_register
   localparam logic [11:0] OFF_INJRES = 12'h008; // injection_result_register
   localparam logic [11:0] OFF_STATUS = 12'h00C; // Sticky event status, read clears
   localparam logic [11:0] OFF_MASK   = 12'h010; // Interrupt mask
   localparam logic [11:0] OFF_DIGIN  = 12'h014; // Digital view of channel inputs
   localparam logic [11:0] OFF_DIGEN  = 12'h018; // Channel digital-input enables

   // ----------------------------------------------------------------
   // Control register field positions
   // ----------------------------------------------------------------
   localparam int CTRL_CHAN_LSB  = 0;  // 4-bit channel (last channel in scan modes)
   localparam int CTRL_MODE_LSB  = 4;  // 2-bit mode
   localparam int CTRL_START_BIT = 7;  // Start, self clearing
   localparam int CTRL_CTC_LSB   = 8;  // 2-bit conversion_clock_select
   localparam int CTRL_STC_LSB   = 10; // 2-bit sample_clock_select
   localparam int CTRL_WFR_BIT   = 12; // wait_for_read_enable
   localparam int CTRL_OVP_BIT   = 13; // 1 = hold off on unread result, 0 = signal overrun unless wait_for_read_enable is set
   localparam int CTRL_INJ_BIT   = 14; // Injection request, self clearing
   localparam int CTRL_INJCH_LSB = 16; // 4-bit injected channel
   localparam int CTRL_BUSY_BIT  = 20; // Busy, read only

   // Status / mask bits
   localparam int EV_DONE = 0; // Regular result stored
   localparam int EV_OVR  = 1; // Overrun
   localparam int EV_INJ  = 2; // Injected result stored
   localparam int EV_NUM  = 3;

   // Reset values
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [15:0] DIGEN_RST = 16'h0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS       = 50;        // REF_CLK period
   localparam int TCL_NS       = 25;        // base_time_unit
   localparam int CTC00_TCL    = 24;
   localparam int CTC10_TCL    = 96;
   localparam int CTC11_TCL    = 48;
   localparam int CTC00_CYC    = (CTC00_TCL * TCL_NS) / CLK_NS;
   localparam int CTC10_CYC    = (CTC10_TCL * TCL_NS) / CLK_NS;
   localparam int CTC11_CYC    = (CTC11_TCL * TCL_NS) / CLK_NS;
   localparam int CONV_STEPS   = 10;        // One conversion clock per result bit
   localparam int CHAN_NUM     = 16;
   localparam int RES_W        = 10;

   typedef enum logic [1:0] {
      ADCSQ_SINGLE      = 2'b00,
      ADCSQ_CONTINUOUS  = 2'b01,
      ADCSQ_SCAN_SINGLE = 2'b10,
      ADCSQ_SCAN_CONT   = 2'b11
   } adcsq_mode_t;

   typedef enum logic [2:0] {
      ADCSQ_IDLE   = 3'b000,
      ADCSQ_SAMPLE = 3'b001,
      ADCSQ_CONV   = 3'b010,
      ADCSQ_STORE  = 3'b011,
      ADCSQ_HOLD   = 3'b100
   } adcsq_state_t;

   // Analog front end request / answer
   typedef struct packed {
      logic       sample; // Sample-and-hold tracking
      logic       start;  // Conversion start pulse
      logic [3:0] chan;   // Multiplexer select
   } adcsq_afe_req_t;

endpackage : adcsq_pkg

// file: logic/adcsq_top.sv
// ADC sequencer control: modes, injection, overrun, clock select and APB registers
//
// Behaviour
// RULE1 - Select one of 16 channels by multiplexer, produce 10-bit result each conversion.
// RULE2 - With overrun signalling, flag interrupt when result completes over unread result.
// RULE3 - With overrun protection, hold next conversion until previous result is read.
// RULE4 - Unused analog inputs readable as plain digital input lines.
// RULE5 - Single-channel single mode converts chosen channel once, stores result.
// RULE6 - Single-channel continuous mode converts chosen channel repeatedly, storing each result.
// RULE7 - Auto scan single converts each selected channel once, storing after each.
// RULE8 - Auto scan continuous sweeps selected channels repeatedly, storing each result.
// RULE9 - Each scan result raises a request serviceable by interrupt or event transfer.
// RULE10 - Wait-for-read in continuous mode parks result in buffer, holds until read.
// RULE11 - Injected single-channel conversion runs between regular ones, mode unchanged.
// RULE12 - Injected 10-bit result goes to injection result register only.
// RULE13 - After injection, the continuous mode resumes without software action.
// RULE14 - Conversion clock code 00/10/11 gives 24/96/48 base units; 01 reserved.
// RULE15 - Sample period is conversion clock times 1, 2, 4 or 8.
// RULE16 - Start bit begins conversion or scan; busy stays high while converting.
`timescale 1ns/1ps
`default_nettype none

module adcsq_top (
   input  wire logic                      REF_CLK,
   input  wire logic                      RESET,
   input  wire logic [11:0]               PADDR,
   input  wire logic                      PSEL,
   input  wire logic                      PENABLE,
   input  wire logic                      PWRITE,
   input  wire logic [31:0]               PWDATA,
   output logic      [31:0]               PRDATA,
   output logic                           PREADY,
   output logic                           PSLVERR,
   output logic                           IRQ,
   output logic                           XFER_REQ,
   input  wire logic                      XFER_ACK,
   output adcsq_pkg::adcsq_afe_req_t      AFE_REQ,
   input  wire logic                      AFE_DONE,
   input  wire logic [9:0]                AFE_RESULT,
   input  wire logic [15:0]               CHAN_DIG_IN
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam int EVN = adcsq_pkg::EV_NUM;

   typedef struct packed {
      logic [31:0]                    ctrl;
      logic [9:0]                     result;
      logic [3:0]                     result_chan;
      logic                           result_full;
      logic [9:0]                     park;
      logic [3:0]                     park_chan;
      logic                           park_full;
      logic [9:0]                     injres;
      logic [3:0]                     inj_chan;
      logic                           inj_pend;
      logic                           inj_act;
      logic [EVN-1:0]                 status;
      logic [EVN-1:0]                 mask;
      logic [15:0]                    digen;
      logic [15:0]                    digin;
      adcsq_pkg::adcsq_state_t        state;
      logic [3:0]                     chan;
      logic [10:0]                    div;
      logic [3:0]                     steps;
      logic                           busy;
      logic [31:0]                    prdata;
      logic                           pready;
      logic                           pslverr;
      logic                           irq;
      logic                           xfer;
      adcsq_pkg::adcsq_afe_req_t      afe;
   } adcsq_state_s_t;

   adcsq_state_s_t st_ff;
   adcsq_state_s_t nxt_st;

   logic        access;
   logic        wr_ok;
   logic        rd_ok;
   logic [10:0] cc_cyc;
   logic [3:0]  smp_steps;
   logic [1:0]  mode;
   logic        cont;
   logic        scan;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   assign access = PSEL && PENABLE && !st_ff.pready;
   assign wr_ok  = access && PWRITE;
   assign rd_ok  = access && !PWRITE;
   assign mode   = st_ff.ctrl[adcsq_pkg::CTRL_MODE_LSB +: 2];
   assign cont   = mode[0];
   assign scan   = mode[1];

   // Conversion clock period in REF_CLK cycles
   always_comb begin
      case (st_ff.ctrl[adcsq_pkg::CTRL_CTC_LSB +: 2])
         2'b10:   cc_cyc = 11'(adcsq_pkg::CTC10_CYC); // RULE14
         2'b11:   cc_cyc = 11'(adcsq_pkg::CTC11_CYC); // RULE14
         default: cc_cyc = 11'(adcsq_pkg::CTC00_CYC); // RULE14
      endcase
   end

   // Sample period length in conversion clocks
   always_comb begin
      case (st_ff.ctrl[adcsq_pkg::CTRL_STC_LSB +: 2])
         2'b01:   smp_steps = 4'h2; // RULE15
         2'b10:   smp_steps = 4'h4; // RULE15
         2'b11:   smp_steps = 4'h8; // RULE15
         default: smp_steps = 4'h1; // RULE15
      endcase
   end

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic         tick;
      logic         read_res;
      logic         read_stat;
      logic         taken;
      logic         next_ok;
      logic [EVN-1:0] ev;
      logic [3:0]   last;
      logic [3:0]   cur_ch;
      tick      = 1'b0;
      read_res  = 1'b0;
      read_stat = 1'b0;
      taken     = 1'b0;
      next_ok   = 1'b0;
      ev        = '0;
      last      = st_ff.ctrl[adcsq_pkg::CTRL_CHAN_LSB +: 4];
      cur_ch    = 4'h0;
      nxt_st    = st_ff;

      nxt_st.pready    = access;
      nxt_st.pslverr   = 1'b0;
      nxt_st.afe.start = 1'b0;
      nxt_st.digin     = CHAN_DIG_IN & st_ff.digen; // RULE4

      // Register writes
      if (wr_ok) begin
         if (PADDR == adcsq_pkg::OFF_CTRL) begin
            nxt_st.ctrl = PWDATA & 32'h001F_7FFF;
            nxt_st.ctrl[adcsq_pkg::CTRL_START_BIT] = PWDATA[adcsq_pkg::CTRL_START_BIT] &&
                                                     !st_ff.busy;
            nxt_st.ctrl[adcsq_pkg::CTRL_INJ_BIT]   = 1'b0;
            if (PWDATA[adcsq_pkg::CTRL_INJ_BIT] && st_ff.busy && cont) begin
               nxt_st.inj_pend = 1'b1; // RULE11
               nxt_st.inj_chan = PWDATA[adcsq_pkg::CTRL_INJCH_LSB +: 4];
            end
            if (st_ff.busy) begin
               nxt_st.ctrl[adcsq_pkg::CTRL_MODE_LSB +: 2] = mode; // Mode fixed while busy
            end
         end else if (PADDR == adcsq_pkg::OFF_MASK) begin
            nxt_st.mask = PWDATA[EVN-1:0];
         end else if (PADDR == adcsq_pkg::OFF_DIGEN) begin
            nxt_st.digen = PWDATA[15:0];
         end else if (PADDR != adcsq_pkg::OFF_RESULT && PADDR != adcsq_pkg::OFF_INJRES &&
                      PADDR != adcsq_pkg::OFF_STATUS && PADDR != adcsq_pkg::OFF_DIGIN) begin
            nxt_st.pslverr = 1'b1;
         end
      end

      // Register reads
      nxt_st.prdata = 32'h0000_0000;
      if (rd_ok) begin
         if (PADDR == adcsq_pkg::OFF_CTRL) begin
            nxt_st.prdata = st_ff.ctrl;
            nxt_st.prdata[adcsq_pkg::CTRL_BUSY_BIT] = st_ff.busy; // RULE16
         end else if (PADDR == adcsq_pkg::OFF_RESULT) begin
            nxt_st.prdata = {16'h0000, st_ff.result_chan, 2'b00, st_ff.result};
            read_res = 1'b1;
         end else if (PADDR == adcsq_pkg::OFF_INJRES) begin
            nxt_st.prdata = {16'h0000, st_ff.inj_chan, 2'b00, st_ff.injres};
         end else if (PADDR == adcsq_pkg::OFF_STATUS) begin
            nxt_st.prdata = {29'h0000_0000, st_ff.status};
            read_stat = 1'b1;
         end else if (PADDR == adcsq_pkg::OFF_MASK) begin
            nxt_st.prdata = {29'h0000_0000, st_ff.mask};
         end else if (PADDR == adcsq_pkg::OFF_DIGIN) begin
            nxt_st.prdata = {16'h0000, st_ff.digin}; // RULE4
         end else if (PADDR == adcsq_pkg::OFF_DIGEN) begin
            nxt_st.prdata = {16'h0000, st_ff.digen};
         end else begin
            nxt_st.pslverr = 1'b1;
         end
      end

      // A result read (or event transfer) empties the result register, or refills it from the parked result
      taken = read_res || (XFER_ACK && st_ff.xfer);
      if (taken) begin
         nxt_st.result_full = 1'b0;
         nxt_st.xfer        = 1'b0;
         if (st_ff.park_full) begin
            nxt_st.result      = st_ff.park; // RULE10
            nxt_st.result_chan = st_ff.park_chan;
            nxt_st.result_full = 1'b1;
            nxt_st.park_full   = 1'b0;
            nxt_st.xfer        = scan; // RULE9
         end
      end

      // Conversion clock divider
      if (st_ff.state == adcsq_pkg::ADCSQ_SAMPLE || st_ff.state == adcsq_pkg::ADCSQ_CONV) begin
         if (st_ff.div >= cc_cyc - 11'h001) begin
            nxt_st.div = 11'h000;
            tick       = 1'b1;
         end else begin
            nxt_st.div = st_ff.div + 11'h001;
         end
      end else begin
         nxt_st.div = 11'h000;
      end

      cur_ch = st_ff.inj_act ? st_ff.inj_chan : st_ff.chan;

      // Sequencer
      case (st_ff.state)
         adcsq_pkg::ADCSQ_IDLE: begin
            if (st_ff.ctrl[adcsq_pkg::CTRL_START_BIT]) begin
               nxt_st.ctrl[adcsq_pkg::CTRL_START_BIT] = 1'b0;
               nxt_st.busy  = 1'b1; // RULE16
               nxt_st.chan  = scan ? 4'h0 : last; // RULE7 RULE8
               nxt_st.steps = 4'h0;
               nxt_st.state = adcsq_pkg::ADCSQ_SAMPLE;
               nxt_st.afe.sample = 1'b1;
               nxt_st.afe.chan   = scan ? 4'h0 : last; // RULE1
            end
         end
         adcsq_pkg::ADCSQ_SAMPLE: begin
            if (tick) begin
               if (st_ff.steps == smp_steps - 4'h1) begin
                  nxt_st.steps      = 4'h0;
                  nxt_st.afe.sample = 1'b0;
                  nxt_st.afe.start  = 1'b1;
                  nxt_st.state      = adcsq_pkg::ADCSQ_CONV;
               end else begin
                  nxt_st.steps = st_ff.steps + 4'h1;
               end
            end
         end
         adcsq_pkg::ADCSQ_CONV: begin
            if (tick && st_ff.steps != 4'(adcsq_pkg::CONV_STEPS - 1)) begin
               nxt_st.steps = st_ff.steps + 4'h1;
            end
            if (AFE_DONE && st_ff.steps == 4'(adcsq_pkg::CONV_STEPS - 1)) begin
               nxt_st.state = adcsq_pkg::ADCSQ_STORE;
               nxt_st.park  = AFE_RESULT; // Capture answer
            end
         end
         adcsq_pkg::ADCSQ_STORE: begin
            if (st_ff.inj_act) begin
               nxt_st.injres  = st_ff.park; // RULE12
               nxt_st.inj_act = 1'b0;       // RULE13
               ev[adcsq_pkg::EV_INJ] = 1'b1;
               next_ok = 1'b1;
            end else if (st_ff.result_full && (st_ff.ctrl[adcsq_pkg::CTRL_WFR_BIT] ||
                         st_ff.ctrl[adcsq_pkg::CTRL_OVP_BIT]) && !taken) begin
               nxt_st.park_full = st_ff.ctrl[adcsq_pkg::CTRL_WFR_BIT]; // RULE10
               nxt_st.park_chan = st_ff.chan;
               nxt_st.state     = adcsq_pkg::ADCSQ_HOLD; // RULE3 RULE10
            end else begin
               if (st_ff.result_full && !taken) begin
                  ev[adcsq_pkg::EV_OVR] = 1'b1; // RULE2
               end
               nxt_st.result      = st_ff.park; // RULE5 RULE6 RULE7 RULE8
               nxt_st.result_chan = st_ff.chan;
               nxt_st.result_full = 1'b1;
               nxt_st.xfer        = scan; // RULE9
               ev[adcsq_pkg::EV_DONE] = 1'b1;
               next_ok = 1'b1;
            end
         end
         adcsq_pkg::ADCSQ_HOLD: begin
            if (taken) begin
               if (!st_ff.park_full) begin
                  nxt_st.result      = st_ff.park; // RULE3
                  nxt_st.result_chan = st_ff.chan;
                  nxt_st.result_full = 1'b1;
                  nxt_st.xfer        = scan;
               end
               ev[adcsq_pkg::EV_DONE] = 1'b1;
               next_ok = 1'b1;
            end
         end
         default: nxt_st.state = adcsq_pkg::ADCSQ_IDLE;
      endcase

      // Choose the next conversion once a result has been placed
      if (next_ok) begin
         if (st_ff.inj_pend && !st_ff.inj_act && cont) begin
            nxt_st.inj_pend = 1'b0;
            nxt_st.inj_act  = 1'b1; // RULE11
            cur_ch          = st_ff.inj_chan;
            nxt_st.state    = adcsq_pkg::ADCSQ_SAMPLE;
         end else if (st_ff.inj_act) begin
            cur_ch       = st_ff.chan; // RULE13
            nxt_st.state = adcsq_pkg::ADCSQ_SAMPLE;
         end else if (scan && st_ff.chan != last) begin
            nxt_st.chan  = st_ff.chan + 4'h1; // RULE7 RULE8
            cur_ch       = st_ff.chan + 4'h1;
            nxt_st.state = adcsq_pkg::ADCSQ_SAMPLE;
         end else if (cont) begin
            nxt_st.chan  = scan ? 4'h0 : last; // RULE6 RULE8
            cur_ch       = scan ? 4'h0 : last;
            nxt_st.state = adcsq_pkg::ADCSQ_SAMPLE;
         end else begin
            nxt_st.state = adcsq_pkg::ADCSQ_IDLE; // RULE5 RULE7
            nxt_st.busy  = 1'b0;
            nxt_st.inj_pend = 1'b0;
         end
         nxt_st.steps      = 4'h0;
         nxt_st.afe.chan   = cur_ch; // RULE1
         nxt_st.afe.sample = (nxt_st.state == adcsq_pkg::ADCSQ_SAMPLE);
      end

      // Sticky status: set wins over read clear
      nxt_st.status = (read_stat ? '0 : st_ff.status) | ev;
      nxt_st.irq    = |(nxt_st.status & st_ff.mask);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         st_ff       <= '0;
         st_ff.ctrl  <= adcsq_pkg::CTRL_RST;
         st_ff.digen <= adcsq_pkg::DIGEN_RST;
         st_ff.state <= adcsq_pkg::ADCSQ_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flip-flops
   assign PRDATA   = st_ff.prdata;
   assign PREADY   = st_ff.pready;
   assign PSLVERR  = st_ff.pslverr;
   assign IRQ      = st_ff.irq;
   assign XFER_REQ = st_ff.xfer;
   assign AFE_REQ  = st_ff.afe;

endmodule : adcsq_top

`default_nettype wire

// file: bench/adcsq_monitor.sv
// Checker of port-level behaviour of the ADC sequencer control block
`timescale 1ns/1ps
`default_nettype none
module adcsq_monitor (
   input wire logic                      REF_CLK,
   input wire logic                      RESET,
   input wire logic                      PSEL,
   input wire logic                      PENABLE,
   input wire logic [31:0]               PRDATA,
   input wire logic                      PREADY,
   input wire logic                      PSLVERR,
   input wire logic                      XFER_REQ,
   input wire logic                      XFER_ACK,
   input wire adcsq_pkg::adcsq_afe_req_t AFE_REQ
);
   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   sequence s_taken;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence s_sampling;
      AFE_REQ.sample [*2];
   endsequence
   // Bus answer and its shape
   a_ready_after_take: assert property (s_taken |=> PREADY) else $error("no answer");
   a_ready_one_cycle: assert property (PREADY |=> !PREADY) else $error("long ready");
   a_ready_in_access: assert property (PREADY |-> $past(PSEL) && $past(PENABLE))
      else $error("stray ready");
   a_err_with_ready: assert property (PSLVERR |-> PREADY) else $error("stray error");
   a_rdata_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
      else $error("data outside answer");
   // Front end sequencing and transfer request
   a_start_one_pulse: assert property (AFE_REQ.start |=> !AFE_REQ.start)
      else $error("long start");
   a_start_not_sampling: assert property (AFE_REQ.start |-> !AFE_REQ.sample)
      else $error("start in sampling");
   a_sample_min_len: assert property ($rose(AFE_REQ.sample) |-> AFE_REQ.sample [*8])
      else $error("short sampling");
   a_chan_held: assert property (s_sampling |-> $stable(AFE_REQ.chan))
      else $error("channel moved");
   a_xfer_cleared: assert property (XFER_REQ && XFER_ACK |=> !XFER_REQ)
      else $error("request kept");
endmodule : adcsq_monitor
bind adcsq_top adcsq_monitor mon_u (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL),
   .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .XFER_REQ(XFER_REQ), .XFER_ACK(XFER_ACK), .AFE_REQ(AFE_REQ));
`default_nettype wire

// file: bench/adcsq_afe_model.sv
// Behavioural analog front end: answers each conversion start after a delay
`timescale 1ns/1ps
`default_nettype none
module adcsq_afe_model #(
   parameter int DLY = 3
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire adcsq_pkg::adcsq_afe_req_t req,
   output logic                           done,
   output logic [9:0]                     result
);
   logic [3:0] ch_ff;
   logic       run_ff;
   int         cnt_ff;
   // Latch channel on start, raise done after delay, hold until next start
   always @(posedge clk) begin
      if (rst) begin
         done   <= 1'b0;
         run_ff <= 1'b0;
         ch_ff  <= 4'h0;
         cnt_ff <= 0;
      end else if (req.start) begin
         ch_ff  <= req.chan;
         cnt_ff <= DLY;
         run_ff <= 1'b1;
         done   <= 1'b0;
      end else if (run_ff) begin
         if (cnt_ff == 0) begin
            done   <= 1'b1;
            run_ff <= 1'b0;
         end else begin
            cnt_ff <= cnt_ff - 1;
         end
      end
   end
   // Data lines show an inverted pattern while no result is offered
   assign result = done ? {ch_ff, 6'h15} : ~{ch_ff, 6'h15};
endmodule : adcsq_afe_model
`default_nettype wire

// file: bench/adcsq_top_test.sv
// Self-checking testbench of the ADC sequencer control block
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_test;
   localparam int LIMIT = 20000; // Cycle ceiling of the run
   logic                      ref_clk, reset, psel, penable, pwrite, pready, pslverr;
   logic                      irq, xfer_req, xfer_ack, afe_done, err;
   logic [11:0]               paddr;
   logic [31:0]               pwdata, prdata, rd;
   logic [9:0]                afe_result;
   logic [15:0]               dig_in;
   adcsq_pkg::adcsq_afe_req_t afe_req;
   int                        bad_count, n_compared, cyc, run_len, last_len;
   logic [1:0]                ctc_t [4] = '{2'b00, 2'b10, 2'b11, 2'b00};
   logic [1:0]                stc_t [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
   int len_t [4] = '{adcsq_pkg::CTC00_CYC, 2 * adcsq_pkg::CTC10_CYC, 4 * adcsq_pkg::CTC11_CYC,
                     8 * adcsq_pkg::CTC00_CYC};

   adcsq_top dut_u (.REF_CLK(ref_clk), .RESET(reset), .PADDR(paddr), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .IRQ(irq), .XFER_REQ(xfer_req), .XFER_ACK(xfer_ack),
      .AFE_REQ(afe_req), .AFE_DONE(afe_done), .AFE_RESULT(afe_result), .CHAN_DIG_IN(dig_in));
   adcsq_afe_model #(.DLY(3)) afe_u (.clk(ref_clk), .rst(reset), .req(afe_req),
      .done(afe_done), .result(afe_result));

   // -------------------------------------------------------------
   // Clock, cycle ceiling and sampling-length meter
   // -------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         bad_count = bad_count + 1;
         complete_run();
      end
      if (afe_req.sample) run_len <= run_len + 1;
      else if (run_len != 0) begin
         last_len <= run_len;
         run_len  <= 0;
      end
   end

   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // One APB transfer, held until ready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic do_reset();
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
   endtask : do_reset

   task automatic wait_idle();
      do apb(1'b0, adcsq_pkg::OFF_CTRL, 32'h0); while (rd[adcsq_pkg::CTRL_BUSY_BIT] !== 1'b0);
   endtask : wait_idle

   function automatic logic [31:0] exp_res(input logic [3:0] ch);
      return {16'h0000, ch, 2'b00, ch, 6'h15};
   endfunction : exp_res

   // Control word, start set, injected channel 9
   function automatic logic [31:0] ctl(input logic [1:0] md, input logic [3:0] ch,
      input logic [1:0] ctc, input logic [1:0] stc, input logic wfr, input logic ovp,
      input logic inj);
      return {11'h000, 1'b0, 4'h9, 1'b0, inj, ovp, wfr, stc, ctc, 1'b1, 1'b0, md, ch};
   endfunction : ctl

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      {reset, psel, penable, pwrite, xfer_ack} = 5'h10;
      {paddr, pwdata, dig_in} = {12'h000, 32'h0000_0000, 16'hA5A5};
      {bad_count, n_compared, cyc, run_len, last_len} = '0;
      do_reset();
      // Reset values, unmapped access, digital view
      foreach (len_t[i]) begin
         apb(1'b0, 12'(4 * i) + adcsq_pkg::OFF_CTRL, 32'h0);
         chk("reset value", rd, 32'h0000_0000);
      end
      apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
      chk("unmapped error", {31'h0, err}, 32'h1);
      apb(1'b1, adcsq_pkg::OFF_DIGEN, 32'h0000_00F0);
      apb(1'b0, adcsq_pkg::OFF_DIGIN, 32'h0);
      chk("digital view", rd, 32'h0000_00A0);
      // Single conversions over clock selections; reserved code never written
      foreach (len_t[i]) begin
         apb(1'b1, adcsq_pkg::OFF_CTRL, ctl(2'b00, 4'(5 * i), ctc_t[i], stc_t[i], 1'b0, 1'b0, 1'b0));
         wait_idle();
         chk("sampling length", 32'(last_len), 32'(len_t[i]));
         apb(1'b0, adcsq_pkg::OFF_RESULT, 32'h0);
         chk("single result", rd, exp_res(4'(5 * i)));
         apb(1'b0, adcsq_pkg::OFF_STATUS, 32'h0);
         chk("done flag", rd & 32'h1, 32'h1);
      end
      // Scan of channels 0..2 with hold-off, served by read or transfer ack
      apb(1'b1, adcsq_pkg::OFF_CTRL, ctl(2'b10, 4'd2, 2'b00, 2'b00, 1'b0, 1'b1, 1'b0));
      for (int i = 0; i < 3; i++) begin
         while (xfer_req !== 1'b1) @(posedge ref_clk);
         if (i == 1) begin
            xfer_ack <= 1'b1;
            @(posedge ref_clk);
            xfer_ack <= 1'b0;
            @(posedge ref_clk);
            chk("request after ack", {31'h0, xfer_req}, 32'h0);
         end else begin
            if (i == 0) repeat (150) @(posedge ref_clk);
            apb(1'b0, adcsq_pkg::OFF_RESULT, 32'h0);
            chk("scan result", rd, exp_res(4'(i)));
         end
         repeat (2) @(posedge ref_clk);
      end
      wait_idle();
      // Continuous mode: overrun signalled, or parked with wait-for-read
      for (int w = 0; w < 2; w++) begin
         do_reset();
         apb(1'b1, adcsq_pkg::OFF_MASK, 32'h0000_0007);
         apb(1'b1, adcsq_pkg::OFF_CTRL, ctl(2'b01, 4'd3, 2'b00, 2'b00, w[0], 1'b0, 1'b0));
         repeat (700) @(posedge ref_clk);
         chk("interrupt", {31'h0, irq}, 32'h1);
         apb(1'b0, adcsq_pkg::OFF_STATUS, 32'h0);
         chk("overrun flag", rd & 32'h3, {30'h0, ~w[0], 1'b1});
         if (w == 1) begin
            apb(1'b0, adcsq_pkg::OFF_RESULT, 32'h0);
            chk("held result", rd, exp_res(4'd3));
         end else begin
            apb(1'b1, adcsq_pkg::OFF_CTRL, ctl(2'b01, 4'd3, 2'b00, 2'b00, 1'b0, 1'b0, 1'b1));
            do apb(1'b0, adcsq_pkg::OFF_INJRES, 32'h0); while (rd[9:0] === 10'h000);
            chk("injected result", rd, exp_res(4'd9));
            apb(1'b0, adcsq_pkg::OFF_CTRL, 32'h0);
            chk("mode kept", rd & 32'h0010_0030, 32'h0010_0010);
         end
      end
      complete_run();
   end
endmodule : adcsq_top_test
`default_nettype wire
